// [psm_pkg.sv]
// Package for the power and system management sequencer.
// Assumes a single 40 MHz clock domain.
package psm_pkg;
  localparam int unsigned CLOCK_HZ       = 40000000;
  localparam int unsigned PRESS_MIN_MS   = 16;
  localparam int unsigned PRESS_CYCLES   = (CLOCK_HZ / 1000) * PRESS_MIN_MS;
  localparam int unsigned RESET_PULSE_US = 1000;
  localparam int unsigned RESET_CYCLES   = (CLOCK_HZ / 1000000) * RESET_PULSE_US;
  localparam int unsigned PENDING_US     = 100;
  localparam int unsigned PENDING_CYCLES = (CLOCK_HZ / 1000000) * PENDING_US;
  localparam int unsigned CNT_W          = 20;
  localparam int unsigned NUM_BUTTONS    = 4;
  localparam int unsigned BTN_POWER      = 0;
  localparam int unsigned BTN_RESET      = 1;
  localparam int unsigned BTN_LID        = 2;
  localparam int unsigned BTN_SLEEP      = 3;

  typedef enum logic [2:0] {
    PSM_SOFT_OFF,
    PSM_WORKING,
    PSM_PENDING,
    PSM_SUSPEND_RAM
  } psm_state_t;
endpackage

// [psm_filter.sv]
// Synchroniser and minimum-width press filter for one active-low input.
// Assumes the input is asynchronous to clock.
`timescale 1ns/1ps
module psm_filter #(
  parameter int unsigned CNT_W = 20,
  parameter int unsigned MIN_CYCLES = 640000
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Pin side
  input  wire logic pin_n,
  // Filtered level, high while pressed
  output logic      pressed,
  output logic      press_pulse,
  output logic      release_pulse
);
  logic             sync_a;
  logic             sync_b;
  logic [CNT_W-1:0] count;
  logic             differs;
  logic             stable;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end
    else
    begin
      sync_a <= pin_n;
      sync_b <= sync_a;
    end
  end

  assign differs = (!sync_b) != pressed;
  assign stable  = count >= CNT_W'(MIN_CYCLES - 1);

  // Only a level held for the minimum width is taken
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      count <= '0;
    else if (!differs || stable)
      count <= '0;
    else
      count <= count + CNT_W'(1);
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      pressed <= 1'b0;
    else if (differs && stable)
      pressed <= !sync_b;
  end

  assign press_pulse   = differs && stable && !sync_b;
  assign release_pulse = differs && stable && sync_b;
endmodule

// [psm_sequencer.sv]
// Power and system management sequencer of the module.
// Assumes all pin inputs are asynchronous; one 40 MHz clock.
`timescale 1ns/1ps
// Notes on behaviour
// - Power button release leaves soft off
// - Reset button active low, edge triggered
// - Holding reset button low does not hold reset
// - Carrier reset from five listed causes
// - Power good high means power good
// - Pending suspend asserted before suspend starts
// - Suspend to RAM output low in suspend
// - Suspend to disk unsupported, held inactive
// - Soft off output driven in soft off
// - Either wake input requests wake
// - Battery low input flags power event
// - Over temperature input flags condition
// - Thermal shutdown output low on CPU trip
// - Management alert raises interrupt or wake
// - Lid and sleep buttons reported as events
module psm_sequencer #(
  parameter int unsigned PRESS_CYCLES   = psm_pkg::PRESS_CYCLES,
  parameter int unsigned RESET_CYCLES   = psm_pkg::RESET_CYCLES,
  parameter int unsigned PENDING_CYCLES = psm_pkg::PENDING_CYCLES
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic resetn,
  // Buttons from carrier
  input  wire logic power_button_n,
  input  wire logic reset_button_n,
  input  wire logic lid_n,
  input  wire logic sleep_button_n,
  // Supply and status from carrier
  input  wire logic main_power_good,
  input  wire logic main_supply_low,
  input  wire logic pcie_wake_in_n,
  input  wire logic general_wake_in_n,
  input  wire logic battery_low_n,
  input  wire logic over_temp_in_n,
  input  wire logic smbus_alert_n,
  // Requests from module logic
  input  wire logic watchdog_timeout,
  input  wire logic software_reset,
  input  wire logic suspend_request,
  input  wire logic power_off_request,
  input  wire logic cpu_thermal_trip,
  // Outputs to carrier
  output logic      carrier_reset_out_n,
  output logic      suspend_pending_n,
  output logic      suspend_to_ram_n,
  output logic      suspend_to_disk_n,
  output logic      soft_off_n,
  output logic      thermal_shutdown_out_n,
  // Events to module logic
  output logic      lid_event,
  output logic      sleep_event,
  output logic      wake_event,
  output logic      battery_low,
  output logic      over_temp,
  output logic      smi_request
);
  localparam int unsigned CNT_W = psm_pkg::CNT_W;
  localparam int unsigned NB    = psm_pkg::NUM_BUTTONS;

  psm_pkg::psm_state_t state;
  psm_pkg::psm_state_t next_state;

  logic [NB-1:0]    btn_pin_n;
  logic [NB-1:0]    btn_pressed;
  logic [NB-1:0]    btn_press;
  logic [NB-1:0]    btn_release;
  logic [5:0]       lvl_a;
  logic [5:0]       lvl_b;
  logic             good;
  logic             supply_low;
  logic             wake_req;
  logic             alert;
  logic             reset_cause;
  logic             level_cause;
  logic [CNT_W-1:0] reset_count;
  logic [CNT_W-1:0] pend_count;
  logic             pend_done;
  logic             trip;

  assign btn_pin_n = {sleep_button_n, lid_n, reset_button_n, power_button_n};

  // Button filters, one per button
  genvar i;
  generate
    for (i = 0; i < NB; i++)
    begin : g_btn
      psm_filter #(
        .CNT_W      (CNT_W),
        .MIN_CYCLES (PRESS_CYCLES)
      ) u_filter (
        .clock         (clock),
        .resetn        (resetn),
        .pin_n         (btn_pin_n[i]),
        .pressed       (btn_pressed[i]),
        .press_pulse   (btn_press[i]),
        .release_pulse (btn_release[i])
      );
    end
  endgenerate

  // Two-stage synchronisers for status pins
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      lvl_a <= 6'h3E;
      lvl_b <= 6'h3E;
    end
    else
    begin
      lvl_a <= {smbus_alert_n, over_temp_in_n, battery_low_n, general_wake_in_n, pcie_wake_in_n, main_power_good};
      lvl_b <= lvl_a;
    end
  end

  // Supply-low flag, synchronised
  logic sl_a;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sl_a       <= 1'b0;
      supply_low <= 1'b0;
    end
    else
    begin
      sl_a       <= main_supply_low;
      supply_low <= sl_a;
    end
  end

  assign good        = lvl_b[0];
  assign wake_req    = !lvl_b[1] || !lvl_b[2] || alert;
  assign alert       = !lvl_b[5];
  assign level_cause = !good || supply_low;
  // Edge of reset button starts a pulse, level does not hold it
  assign reset_cause = btn_press[psm_pkg::BTN_RESET] || watchdog_timeout || software_reset;

  // Carrier reset pulse stretcher
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      reset_count <= CNT_W'(RESET_CYCLES);
    else if (reset_cause)
      reset_count <= CNT_W'(RESET_CYCLES);
    else if (reset_count != '0)
      reset_count <= reset_count - CNT_W'(1);
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      carrier_reset_out_n <= 1'b0;
    else
      carrier_reset_out_n <= !(level_cause || reset_cause || reset_count != '0);
  end

  // Suspend warning interval
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      pend_count <= '0;
    else if (state != psm_pkg::PSM_PENDING)
      pend_count <= '0;
    else if (!pend_done)
      pend_count <= pend_count + CNT_W'(1);
  end

  assign pend_done = pend_count >= CNT_W'(PENDING_CYCLES - 1);

  // Power state machine
  always_comb
  begin
    next_state = state;
    unique case (state)
      psm_pkg::PSM_SOFT_OFF:
        if (btn_release[psm_pkg::BTN_POWER] && good)
          next_state = psm_pkg::PSM_WORKING;
      psm_pkg::PSM_WORKING:
        if (power_off_request || btn_press[psm_pkg::BTN_POWER])
          next_state = psm_pkg::PSM_SOFT_OFF;
        else if (suspend_request || btn_press[psm_pkg::BTN_SLEEP])
          next_state = psm_pkg::PSM_PENDING;
      psm_pkg::PSM_PENDING:
        if (pend_done)
          next_state = psm_pkg::PSM_SUSPEND_RAM;
      psm_pkg::PSM_SUSPEND_RAM:
        if (wake_req || btn_press[psm_pkg::BTN_SLEEP] || btn_release[psm_pkg::BTN_POWER])
          next_state = psm_pkg::PSM_WORKING;
      default:
        next_state = psm_pkg::PSM_SOFT_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      state <= psm_pkg::PSM_SOFT_OFF;
    else
      state <= next_state;
  end

  // Thermal trip latches until reset
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      trip <= 1'b0;
    else if (cpu_thermal_trip)
      trip <= 1'b1;
  end

  // Registered outputs
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      suspend_pending_n      <= 1'b1;
      suspend_to_ram_n       <= 1'b1;
      suspend_to_disk_n      <= 1'b1;
      soft_off_n             <= 1'b0;
      thermal_shutdown_out_n <= 1'b1;
      lid_event              <= 1'b0;
      sleep_event            <= 1'b0;
      wake_event             <= 1'b0;
      battery_low            <= 1'b0;
      over_temp              <= 1'b0;
      smi_request            <= 1'b0;
    end
    else
    begin
      suspend_pending_n      <= !(next_state == psm_pkg::PSM_PENDING ||
                                  next_state == psm_pkg::PSM_SUSPEND_RAM);
      suspend_to_ram_n       <= !(next_state == psm_pkg::PSM_SUSPEND_RAM ||
                                  next_state == psm_pkg::PSM_SOFT_OFF);
      suspend_to_disk_n      <= 1'b1;
      soft_off_n             <= next_state != psm_pkg::PSM_SOFT_OFF;
      thermal_shutdown_out_n <= !(trip || cpu_thermal_trip);
      lid_event              <= btn_press[psm_pkg::BTN_LID] || btn_release[psm_pkg::BTN_LID];
      sleep_event            <= btn_press[psm_pkg::BTN_SLEEP];
      wake_event             <= wake_req && state == psm_pkg::PSM_SUSPEND_RAM;
      battery_low            <= !lvl_b[3];
      over_temp              <= !lvl_b[4];
      smi_request            <= alert && state == psm_pkg::PSM_WORKING;
    end
  end
endmodule

// [psm_monitor.sv]
// Checker of the sequencer's output timing.
// Assumes binding to psm_sequencer; one clock domain.
`timescale 1ns/1ps
module psm_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Causes
  input wire logic watchdog_timeout,
  input wire logic software_reset,
  input wire logic cpu_thermal_trip,
  input wire logic main_power_good,
  // Outputs
  input wire logic carrier_reset_out_n,
  input wire logic suspend_pending_n,
  input wire logic suspend_to_ram_n,
  input wire logic suspend_to_disk_n,
  input wire logic soft_off_n,
  input wire logic thermal_shutdown_out_n,
  input wire logic lid_event
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_trip; cpu_thermal_trip |=> !thermal_shutdown_out_n; endproperty
  a_trip: assert property (p_trip) else $error("no shutdown after trip");
  property p_stick; !thermal_shutdown_out_n |=> !thermal_shutdown_out_n; endproperty
  a_stick: assert property (p_stick) else $error("shutdown released");
  property p_disk; suspend_to_disk_n; endproperty
  a_disk: assert property (p_disk) else $error("disk state shown");
  property p_wd; watchdog_timeout |=> !carrier_reset_out_n [*5]; endproperty
  a_wd: assert property (p_wd) else $error("watchdog reset short");
  property p_sw; software_reset |=> !carrier_reset_out_n; endproperty
  a_sw: assert property (p_sw) else $error("software reset missing");
  property p_pg; $fell(main_power_good) |-> ##[1:5] !carrier_reset_out_n; endproperty
  a_pg: assert property (p_pg) else $error("power loss no reset");
  property p_pend; $fell(suspend_to_ram_n) && soft_off_n |-> $past(suspend_pending_n) == 1'b0; endproperty
  a_pend: assert property (p_pend) else $error("suspend without pending");
  property p_s3; !suspend_to_ram_n |-> !suspend_pending_n || !soft_off_n; endproperty
  a_s3: assert property (p_s3) else $error("ram state outside suspend");
  property p_lid; lid_event |=> !lid_event; endproperty
  a_lid: assert property (p_lid) else $error("lid event too long");
endmodule

bind psm_sequencer psm_monitor i_psm_monitor (.clock, .resetn, .watchdog_timeout, .software_reset,
  .cpu_thermal_trip, .main_power_good, .carrier_reset_out_n, .suspend_pending_n, .suspend_to_ram_n,
  .suspend_to_disk_n, .soft_off_n, .thermal_shutdown_out_n, .lid_event);

// [psm_carrier.sv]
// Carrier board model: buttons, supply and sensors.
// Assumes the sequencer samples every pin on clock.
`timescale 1ns/1ps
module psm_carrier (
  // Clock
  input  wire logic       clock,
  // Status from module
  input  wire logic       suspend_to_ram_n,
  // Pins to module, and rail state
  output logic      [3:0] btn_n,
  output logic      [2:0] wk_n,
  output logic            pg,
  output logic            sl,
  output logic            bat_n,
  output logic            tmp_n,
  output logic            supply_rails_on
);
  initial
  begin
    btn_n = 4'hF;
    wk_n = 3'h7;
    pg = 1'b1;
    sl = 1'b0;
    bat_n = 1'b1;
    tmp_n = 1'b1;
  end
  // Rails follow the inverted ram state output
  assign supply_rails_on = ~suspend_to_ram_n;
  // Press held for the given count
  task automatic press(input int i, input int n);
    @(posedge clock);
    btn_n[i] <= 1'b0;
    repeat (n) @(posedge clock);
    btn_n[i] <= 1'b1;
  endtask
endmodule

// [power_system_management_tb.sv]
// Self-checking bench of the sequencer with a carrier model.
// Assumes shortened counts and a 40 MHz clock.
`timescale 1ns/1ps
module power_system_management_tb;
  localparam int PC = 8;
  localparam int RC = 5;
  localparam int QC = 4;
  logic       clock = 1'b0;
  logic       resetn = 1'b0;
  logic [4:0] req = 5'h00;
  logic [3:0] btn_n;
  logic [2:0] wk_n;
  logic       pg, sl, bat_n, tmp_n, rails, rst_n, pend_n, s3_n, s4_n, off_n, trip_n;
  logic       lid_ev, slp_ev, wake_ev, bat, ot, smi;
  int         errors = 0;
  int         num_checks = 0;
  always #12.5 clock = ~clock;
  psm_carrier i_psm_carrier (.clock(clock), .suspend_to_ram_n(s3_n), .btn_n(btn_n), .wk_n(wk_n), .pg(pg),
    .sl(sl), .bat_n(bat_n), .tmp_n(tmp_n), .supply_rails_on(rails));
  psm_sequencer #(.PRESS_CYCLES(PC), .RESET_CYCLES(RC), .PENDING_CYCLES(QC)) i_psm_sequencer (
    .clock(clock), .resetn(resetn), .power_button_n(btn_n[0]), .reset_button_n(btn_n[1]), .lid_n(btn_n[2]),
    .sleep_button_n(btn_n[3]), .main_power_good(pg), .main_supply_low(sl), .pcie_wake_in_n(wk_n[0]),
    .general_wake_in_n(wk_n[1]), .battery_low_n(bat_n), .over_temp_in_n(tmp_n), .smbus_alert_n(wk_n[2]),
    .watchdog_timeout(req[0]), .software_reset(req[1]), .suspend_request(req[2]), .power_off_request(req[3]),
    .cpu_thermal_trip(req[4]), .carrier_reset_out_n(rst_n), .suspend_pending_n(pend_n), .suspend_to_ram_n(s3_n),
    .suspend_to_disk_n(s4_n), .soft_off_n(off_n), .thermal_shutdown_out_n(trip_n), .lid_event(lid_ev),
    .sleep_event(slp_ev), .wake_event(wake_ev), .battery_low(bat), .over_temp(ot), .smi_request(smi));
  task automatic wait_c(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic ok);
    #1;
    num_checks++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("[FAIL] %0t output mismatch", $time);
    end
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    req[k] <= 1'b1;
    @(posedge clock);
    req[k] <= 1'b0;
  endtask
  task automatic count_rst(input int n, output int c);
    c = 0;
    repeat (n)
    begin
      #1;
      if (rst_n === 1'b0) c++;
      @(posedge clock);
    end
  endtask
  task automatic t_boot;
    wait_c(RC + 6);
    chk(rst_n === 1'b1 && off_n === 1'b0);
    i_psm_carrier.press(0, 16);
    chk(off_n === 1'b0);
    wait_c(PC + 6);
    chk(off_n === 1'b1 && s3_n === 1'b1 && rails === 1'b0);
  endtask
  task automatic t_rst;
    int c;
    fork
      i_psm_carrier.press(1, 40);
      count_rst(60, c);
    join
    chk(c == RC + 1);
    fork
      i_psm_carrier.press(1, 4);
      count_rst(30, c);
    join
    chk(c == 0);
    for (int k = 0; k < 2; k++)
    begin
      pulse(k);
      count_rst(20, c);
      chk(c == RC + 1);
    end
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clock);
      if (k == 0) i_psm_carrier.pg <= 1'b0;
      else i_psm_carrier.sl <= 1'b1;
      fork
        begin
          wait_c(12);
          i_psm_carrier.pg <= 1'b1;
          i_psm_carrier.sl <= 1'b0;
        end
        count_rst(40, c);
      join
      chk(c >= 12 && rst_n === 1'b1);
    end
  endtask
  task automatic t_status;
    @(posedge clock);
    i_psm_carrier.bat_n <= 1'b0;
    i_psm_carrier.tmp_n <= 1'b0;
    i_psm_carrier.wk_n[2] <= 1'b0;
    wait_c(6);
    chk(bat === 1'b1 && ot === 1'b1 && smi === 1'b1);
    i_psm_carrier.bat_n <= 1'b1;
    i_psm_carrier.tmp_n <= 1'b1;
    i_psm_carrier.wk_n[2] <= 1'b1;
    wait_c(6);
    chk(bat === 1'b0 && ot === 1'b0 && smi === 1'b0);
  endtask
  task automatic t_events;
    int nl;
    int ns;
    nl = 0;
    ns = 0;
    fork
      begin
        i_psm_carrier.press(2, 16);
        wait_c(20);
        i_psm_carrier.press(3, 16);
      end
      repeat (90)
      begin
        @(posedge clock);
        #1;
        if (lid_ev === 1'b1) nl++;
        if (slp_ev === 1'b1) ns++;
      end
    join
    chk(nl == 2 && ns == 1 && s3_n === 1'b0);
    i_psm_carrier.press(3, 16);
    wait_c(PC + 6);
    chk(s3_n === 1'b1);
  endtask
  task automatic t_wake;
    int nw;
    for (int k = 0; k < 3; k++)
    begin
      pulse(2);
      wait_c(1);
      chk(pend_n === 1'b0 && s3_n === 1'b1);
      wait_c(QC + 3);
      chk(s3_n === 1'b0 && rails === 1'b1);
      @(posedge clock);
      i_psm_carrier.wk_n[k] <= 1'b0;
      nw = 0;
      repeat (8)
      begin
        @(posedge clock);
        #1;
        if (wake_ev === 1'b1) nw++;
      end
      chk(s3_n === 1'b1 && pend_n === 1'b1 && nw == 1);
      @(posedge clock);
      i_psm_carrier.wk_n[k] <= 1'b1;
      wait_c(4);
    end
  endtask
  task automatic t_off;
    pulse(3);
    wait_c(2);
    chk(off_n === 1'b0 && trip_n === 1'b1 && s4_n === 1'b1);
    pulse(4);
    wait_c(3);
    chk(trip_n === 1'b0);
    @(posedge clock);
    resetn <= 1'b0;
    wait_c(3);
    chk(trip_n === 1'b1 && rst_n === 1'b0 && off_n === 1'b0);
    @(posedge clock);
    resetn <= 1'b1;
    wait_c(RC + 6);
    chk(trip_n === 1'b1 && rst_n === 1'b1 && off_n === 1'b0 && s4_n === 1'b1);
  endtask
  task automatic give_verdict;
    if (errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    wait_c(3);
    resetn <= 1'b1;
    t_boot();
    t_rst();
    t_status();
    t_events();
    t_wake();
    t_off();
    give_verdict();
  end
  initial
  begin
    #200000;
    errors++;
    $display("[FAIL] %0t timeout", $time);
    give_verdict();
  end
endmodule
